// File: hdl/rds_rx_detect.sv
// rds_rx_detect: strap latch, mode and gain decode, receiver-detect engine.
// assumes straps are resolved to two-bit levels by an analog comparator,
// and a far-end detect probe answers within one poll interval.
// Function
// [RULE1] detect sequence at power-up and after reset
// [RULE2] detect strap L0: no detect, 50 ohm
// [RULE3] hi-z before detection, 50 ohm after
// [RULE4] repeat attempt every 150 us
// [RULE5] L1 needs three consecutive valid detections
// [RULE6] L2 needs two consecutive valid detections
// [RULE7] L3 completes on first valid detection
// [RULE8] power-down forces manual reset, hi-z inputs
// [RULE9] pin mode decodes gain strap to gain
// [RULE10] bus modes take gain from register value
// [RULE11] mode strap: pin, controller, target, reserved
// [RULE12] gain and detect pins double as sda/scl
// [RULE13] each strap resolves to one of four levels
// [RULE14] sample straps once after power-on reset
// [RULE15] interval counter reloads, count clears on power-down
// [RULE16] latched strap codes hold until reset
`timescale 1ns/1ps
module rds_rx_detect
    import rds_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [1:0] mode_level_in,
    input wire logic [1:0] gain_level_in,
    input wire logic [1:0] detect_policy_strap_in,
    input wire logic power_down_input_in,
    input wire logic term_valid_in,
    input wire logic signed [2:0] reg_gain_in,
    output logic [1:0] mode_out,
    output logic bus_mode_out,
    output logic signed [2:0] dc_gain_out,
    output logic term_50_out,
    output logic probe_out,
    output logic detect_done_out,
    output logic [1:0] valid_cnt_out
);
    typedef enum logic [2:0] {
        RDS_ST_SAMPLE,
        RDS_ST_OFF,
        RDS_ST_WAIT,
        RDS_ST_PROBE,
        RDS_ST_DONE,
        RDS_ST_PDN
    } rds_state_e;

    logic [1:0] mode_sync, gain_sync, det_sync;
    logic pdn_s1_reg, pdn_s2_reg, pdn_s3_reg, pdn_reg, pdn_next;
    logic tv_s1_reg, tv_s2_reg, tv_s3_reg, tv_reg, tv_next;
    logic [1:0] mode_reg, mode_next, gain_reg, gain_next, det_reg, det_next;
    logic [RDS_POLL_W-1:0] tmr_reg, tmr_next;
    logic [1:0] cnt_reg, cnt_next;
    rds_state_e st_reg, st_next;
    logic signed [2:0] gain_q_reg, gain_q_next;

    // consecutive detections needed for a given policy level
    function automatic logic [1:0] need_count(input logic [1:0] lvl);
        case (lvl)
            RDS_L1: need_count = 2'h3;
            RDS_L2: need_count = 2'h2;
            default: need_count = 2'h1;
        endcase
    endfunction

    // straps resolve to four levels and pass the pin synchroniser [RULE13]
    rds_level_sync u_mode_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .level_in(mode_level_in),
        .level_out(mode_sync)
    );
    rds_level_sync u_gain_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .level_in(gain_level_in),
        .level_out(gain_sync)
    );
    rds_level_sync u_det_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .level_in(detect_policy_strap_in),
        .level_out(det_sync)
    );

    // single-bit pin filters: accept when stages two and three agree
    always_comb begin
        pdn_next = pdn_reg;
        tv_next = tv_reg;
        if (pdn_s2_reg == pdn_s3_reg) begin
            pdn_next = pdn_s3_reg;
        end
        if (tv_s2_reg == tv_s3_reg) begin
            tv_next = tv_s3_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pdn_s1_reg <= 1'b0;
            pdn_s2_reg <= 1'b0;
            pdn_s3_reg <= 1'b0;
            pdn_reg <= 1'b0;
            tv_s1_reg <= 1'b0;
            tv_s2_reg <= 1'b0;
            tv_s3_reg <= 1'b0;
            tv_reg <= 1'b0;
        end else begin
            pdn_s1_reg <= power_down_input_in;
            pdn_s2_reg <= pdn_s1_reg;
            pdn_s3_reg <= pdn_s2_reg;
            pdn_reg <= pdn_next;
            tv_s1_reg <= term_valid_in;
            tv_s2_reg <= tv_s1_reg;
            tv_s3_reg <= tv_s2_reg;
            tv_reg <= tv_next;
        end
    end

    // detect engine and strap latch; strap capture waits for the
    // synchroniser to flush so a stale reset value is never latched
    always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        cnt_next = cnt_reg;
        mode_next = mode_reg;
        gain_next = gain_reg;
        det_next = det_reg;
        case (st_reg)
            RDS_ST_SAMPLE: begin
                if (tmr_reg == 14'(RDS_SAMPLE_WAIT)) begin
                    // one-time capture after reset release [RULE14] [RULE16]
                    mode_next = mode_sync;
                    gain_next = gain_sync;
                    det_next = det_sync;
                    tmr_next = '0;
                    st_next = RDS_ST_WAIT; // start detect [RULE1]
                end else begin
                    tmr_next = tmr_reg + 14'h0001;
                end
            end
            RDS_ST_OFF: begin
                st_next = RDS_ST_OFF; // detection disabled [RULE2]
            end
            RDS_ST_WAIT: begin
                // interval pacing, reloaded each attempt [RULE4] [RULE15]
                if (tmr_reg == 14'(RDS_POLL_CYCLES - 1)) begin
                    tmr_next = '0;
                    st_next = RDS_ST_PROBE;
                end else begin
                    tmr_next = tmr_reg + 14'h0001;
                end
            end
            RDS_ST_PROBE: begin
                if (tv_reg) begin
                    // [RULE5] [RULE6] [RULE7]
                    if (cnt_reg + 2'h1 >= need_count(det_reg)) begin
                        cnt_next = cnt_reg + 2'h1;
                        st_next = RDS_ST_DONE;
                    end else begin
                        cnt_next = cnt_reg + 2'h1;
                        st_next = RDS_ST_WAIT;
                    end
                end else begin
                    cnt_next = RDS_CNT_RST; // miss restarts the run [RULE5]
                    st_next = RDS_ST_WAIT;
                end
            end
            RDS_ST_DONE: begin
                st_next = RDS_ST_DONE;
            end
            RDS_ST_PDN: begin
                // release re-runs detection [RULE1] [RULE8]
                if (!pdn_reg) begin
                    st_next = RDS_ST_WAIT;
                end
            end
            default: begin
                st_next = RDS_ST_SAMPLE;
            end
        endcase
        // policy L0 forces disable once straps are known [RULE2]
        if (st_reg != RDS_ST_SAMPLE && det_reg == RDS_L0) begin
            st_next = RDS_ST_OFF;
        end
        // power-down overrides every policy [RULE8] [RULE15]
        if (st_reg != RDS_ST_SAMPLE && pdn_reg) begin
            st_next = RDS_ST_PDN;
            cnt_next = RDS_CNT_RST;
            tmr_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= RDS_ST_SAMPLE;
            tmr_reg <= '0;
            cnt_reg <= RDS_CNT_RST;
            mode_reg <= RDS_STRAP_RST;
            gain_reg <= RDS_STRAP_RST;
            det_reg <= RDS_STRAP_RST;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            cnt_reg <= cnt_next;
            mode_reg <= mode_next;
            gain_reg <= gain_next;
            det_reg <= det_next;
        end
    end

    // gain source: strap in pin mode, register value in bus modes, zero in reserved mode
    always_comb begin
        gain_q_next = RDS_GAIN_0;
        if (mode_reg == RDS_MODE_PIN) begin
            case (gain_reg) // [RULE9]
                RDS_L0: gain_q_next = RDS_GAIN_M6;
                RDS_L1: gain_q_next = RDS_GAIN_M3;
                RDS_L2: gain_q_next = RDS_GAIN_P3;
                default: gain_q_next = RDS_GAIN_0;
            endcase
        end else if (mode_reg != RDS_MODE_RSVD) begin
            gain_q_next = reg_gain_in; // [RULE10]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            gain_q_reg <= RDS_GAIN_0;
        end else begin
            gain_q_reg <= gain_q_next;
        end
    end

    // [RULE11] mode decode; [RULE12] bus modes turn gain/detect pins
    // into sda/scl, so the gain strap code is ignored downstream; the detect strap code still sets the policy
    assign mode_out = mode_reg;
    assign bus_mode_out = (mode_reg == RDS_MODE_CTRL) ||
                          (mode_reg == RDS_MODE_TGT);
    assign dc_gain_out = gain_q_reg;
    // termination: 50 ohm when disabled or done, hi-z otherwise [RULE3]
    assign term_50_out = (st_reg == RDS_ST_OFF) || (st_reg == RDS_ST_DONE);
    assign probe_out = (st_reg == RDS_ST_PROBE);
    assign detect_done_out = (st_reg == RDS_ST_DONE);
    assign valid_cnt_out = cnt_reg;

    // cycles since the last attempt; feeds only the interval check,
    // cleared wherever the engine itself restarts its pacing
    logic [RDS_POLL_W-1:0] gap_reg, gap_next;

    always_comb begin
        gap_next = gap_reg + 14'h0001;
        if (probe_out || st_reg == RDS_ST_SAMPLE ||
                st_reg == RDS_ST_PDN) begin
            gap_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            gap_reg <= '0;
        end else begin
            gap_reg <= gap_next;
        end
    end

    // all checks share the one clock and stay quiet during reset
    default clocking rds_cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_pdn_hiz: assert property ( // [RULE8]
        pdn_reg && st_reg != RDS_ST_SAMPLE |=> !term_50_out)
        else $error("termination not hi-z in power-down");
    a_pdn_count: assert property ( // [RULE15]
        pdn_reg && st_reg != RDS_ST_SAMPLE |=> valid_cnt_out == 2'h0)
        else $error("power-down did not clear run count");
    a_off_term: assert property ( // [RULE2]
        st_reg != RDS_ST_SAMPLE && det_reg == RDS_L0 && !pdn_reg
        |=> term_50_out)
        else $error("disabled detect must give 50 ohm");
    a_miss_clear: assert property ( // [RULE5]
        probe_out && !tv_reg |=> cnt_reg == 2'h0)
        else $error("miss did not clear run count");
    a_three_need: assert property ( // [RULE5]
        $rose(detect_done_out) && det_reg == RDS_L1 |-> cnt_reg == 2'h3)
        else $error("policy L1 done without three hits");
    a_two_need: assert property ( // [RULE6]
        $rose(detect_done_out) && det_reg == RDS_L2 |-> cnt_reg == 2'h2)
        else $error("policy L2 done without two hits");
    a_one_need: assert property ( // [RULE7]
        $rose(detect_done_out) && det_reg == RDS_L3 |-> cnt_reg == 2'h1)
        else $error("policy L3 done without one hit");
    a_done_probe: assert property ( // [RULE3]
        $rose(detect_done_out) |-> $past(probe_out) && $past(tv_reg))
        else $error("detection completed without a valid attempt");
    a_poll_space: assert property ( // [RULE4]
        probe_out |=> !probe_out [*8])
        else $error("probes too close together");
    a_poll_gap: assert property ( // [RULE4] [RULE15]
        probe_out |-> gap_reg == 14'(RDS_POLL_CYCLES))
        else $error("attempt interval differs from the poll period");
    a_strap_hold: assert property ( // [RULE16]
        st_reg != RDS_ST_SAMPLE
        |=> $stable(mode_reg) && $stable(gain_reg) && $stable(det_reg))
        else $error("strap code changed after capture");
    a_gain_pin: assert property ( // [RULE9]
        mode_reg == RDS_MODE_PIN && gain_reg == RDS_L0
        |=> dc_gain_out == RDS_GAIN_M6)
        else $error("pin-mode gain decode wrong");
    c_done: cover property (@(posedge clk_in) $rose(detect_done_out));
    c_miss: cover property (@(posedge clk_in) probe_out && !tv_reg);
    c_pdn: cover property (@(posedge clk_in) st_reg == RDS_ST_PDN);
    c_off: cover property (@(posedge clk_in) st_reg == RDS_ST_OFF);
endmodule

// File: hdl/rds_pkg.sv
// rds_pkg: constants and types shared by the strap and detect logic.
// assumes a 40 MHz system clock and strap levels already resolved to codes.
package rds_pkg;
    // four-level strap codes
    typedef enum logic [1:0] {
        RDS_L0,
        RDS_L1,
        RDS_L2,
        RDS_L3
    } rds_level_e;

    // clock and timing
    localparam int RDS_CLK_MHZ = 40;
    localparam int RDS_POLL_US = 150;
    localparam int RDS_POLL_CYCLES = RDS_POLL_US * RDS_CLK_MHZ;
    localparam int RDS_POLL_W = 14;
    // edges after reset release before straps are captured; long enough
    // for the three-stage pin filter to flush its reset value
    localparam int RDS_SAMPLE_WAIT = 5;

    // level field width on the level-resolver inputs
    localparam int RDS_LVL_W = 2;

    // reset values
    localparam logic [1:0] RDS_STRAP_RST = 2'h3;
    localparam logic [1:0] RDS_CNT_RST = 2'h0;

    // mode strap decode
    localparam logic [1:0] RDS_MODE_PIN = 2'h0;
    localparam logic [1:0] RDS_MODE_CTRL = 2'h1;
    localparam logic [1:0] RDS_MODE_TGT = 2'h2;
    localparam logic [1:0] RDS_MODE_RSVD = 2'h3;

    // dc gain codes in steps of 3 dB, signed
    localparam logic signed [2:0] RDS_GAIN_M6 = 3'sh6;
    localparam logic signed [2:0] RDS_GAIN_M3 = 3'sh7;
    localparam logic signed [2:0] RDS_GAIN_P3 = 3'sh1;
    localparam logic signed [2:0] RDS_GAIN_0 = 3'sh0;
endpackage

// File: hdl/rds_level_sync.sv
// rds_level_sync: three-stage synchroniser for one two-bit strap level.
// assumes the level comes from a pin comparator outside the clock domain.
`timescale 1ns/1ps
module rds_level_sync
    import rds_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [1:0] level_in,
    output logic [1:0] level_out
);
    logic [1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [1:0] q_next;

    // change accepted only when the last two stages agree
    always_comb begin
        q_next = q_reg;
        if (s2_reg == s3_reg) begin
            q_next = s3_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s1_reg <= RDS_STRAP_RST;
            s2_reg <= RDS_STRAP_RST;
            s3_reg <= RDS_STRAP_RST;
            q_reg <= RDS_STRAP_RST;
        end else begin
            s1_reg <= level_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign level_out = q_reg;
endmodule

// File: tb/rds_far_end.sv
// rds_far_end: far-end receiver termination as seen by the detect probe.
// assumes the bench loads a list of probe outcomes while no probe is due.
`timescale 1ns/1ps
module rds_far_end (
    input wire logic clk_in,
    input wire logic load_in,
    input wire logic [7:0] pattern_in,
    input wire logic probe_in,
    output logic term_valid_out
);
    logic [7:0] pat_reg = 8'h00;

    // one outcome per probe; shifting just after a probe keeps the level
    // steady for the whole next interval, well ahead of the input filter
    always @(posedge clk_in) begin
        if (load_in) begin
            pat_reg <= pattern_in;
        end else if (probe_in) begin
            pat_reg <= {1'b0, pat_reg[7:1]};
        end
    end
    assign term_valid_out = pat_reg[0];
endmodule

// File: tb/testbench.sv
// testbench: strap decode and receiver-detect sequences of rds_rx_detect.
// assumes a 40 MHz clock; inputs move 1 ns after the rising edge.
`timescale 1ns/1ps
module testbench;
    import rds_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [1:0] mode_level_in = 2'h0;
    logic [1:0] gain_level_in = 2'h3;
    logic [1:0] detect_policy_strap_in = 2'h3;
    logic power_down_input_in = 1'b0;
    logic term_valid_in;
    logic signed [2:0] reg_gain_in = 3'sh0;
    logic [1:0] mode_out;
    logic bus_mode_out;
    logic signed [2:0] dc_gain_out;
    logic term_50_out;
    logic probe_out;
    logic detect_done_out;
    logic [1:0] valid_cnt_out;
    logic load = 1'b0;
    logic [7:0] pattern = 8'h00;
    logic signed [2:0] gains [4];
    logic signed [2:0] exp_gain;
    int errors = 0;
    int checks = 0;
    int n;

    rds_rx_detect rds_rx_detect_inst (
        .clk_in(clk_in), .nrst_in(nrst_in),
        .mode_level_in(mode_level_in), .gain_level_in(gain_level_in),
        .detect_policy_strap_in(detect_policy_strap_in),
        .power_down_input_in(power_down_input_in),
        .term_valid_in(term_valid_in), .reg_gain_in(reg_gain_in),
        .mode_out(mode_out), .bus_mode_out(bus_mode_out),
        .dc_gain_out(dc_gain_out), .term_50_out(term_50_out),
        .probe_out(probe_out), .detect_done_out(detect_done_out),
        .valid_cnt_out(valid_cnt_out)
    );
    rds_far_end rds_far_end_inst (
        .clk_in(clk_in), .load_in(load), .pattern_in(pattern),
        .probe_in(probe_out), .term_valid_out(term_valid_in)
    );

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    task summarize();
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // drive and sample 1 ns after the edge, once the design has settled
    task tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // straps sit steady through reset; capture lands 6 edges after release
    task start(input logic [1:0] m, input logic [1:0] g, input logic [1:0] d);
        mode_level_in = m;
        gain_level_in = g;
        detect_policy_strap_in = d;
        nrst_in = 1'b0;
        tick(2);
        nrst_in = 1'b1;
        tick(8);
    endtask

    task load_far(input logic [7:0] p);
        pattern = p;
        load = 1'b1;
        tick(1);
        load = 1'b0;
    endtask

    // bounded wait for a probe; returns with n at the bound if none comes
    task wait_probe(input int lim);
        n = 0;
        while (probe_out !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    // one detect attempt: interval window, then count and termination
    task step(input int lo, input int hi, input logic [1:0] c, input logic d);
        wait_probe(7000);
        if (n >= 7000) begin
            errors++;
            summarize();
        end
        chk(n >= lo && n <= hi, 1'b1);
        tick(1);
        chk(detect_done_out, d);
        chk(term_50_out, d);
        if (!d) begin
            chk(valid_cnt_out, c);
        end
    endtask

    initial begin
        gains = '{RDS_GAIN_M6, RDS_GAIN_M3, RDS_GAIN_P3, RDS_GAIN_0};
        // every mode against every gain level; detect policy held off
        for (int m = 0; m < 4; m++) begin
            for (int g = 0; g < 4; g++) begin
                reg_gain_in = gains[(g + 1) % 4];
                exp_gain = (m == 0) ? gains[g] : reg_gain_in;
                exp_gain = (m == 3) ? RDS_GAIN_0 : exp_gain;
                start(m[1:0], g[1:0], 2'h0);
                chk(mode_out, m[1:0]);
                chk(bus_mode_out, m == 1 || m == 2);
                chk(dc_gain_out, exp_gain);
                chk(term_50_out, 1'b1);
                mode_level_in = ~m[1:0];
                gain_level_in = ~g[1:0];
                tick(8);
                chk(mode_out, m[1:0]);
                chk(dc_gain_out, exp_gain);
            end
        end
        wait_probe(6100);
        chk(n == 6100, 1'b1);
        chk(term_50_out, 1'b1);
        // three in a row, with a miss that restarts the run
        load_far(8'h1d);
        start(2'h0, 2'h3, 2'h1);
        chk(term_50_out, 1'b0);
        step(0, 7000, 2'h1, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h0, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h1, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h2, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h0, 1'b1);
        // two in a row
        load_far(8'h03);
        start(2'h0, 2'h3, 2'h2);
        step(0, 7000, 2'h1, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h0, 1'b1);
        // first hit, then a forced re-detection by the power-down pin
        load_far(8'h05);
        start(2'h0, 2'h3, 2'h3);
        step(0, 7000, 2'h0, 1'b1);
        power_down_input_in = 1'b1;
        tick(8);
        chk(term_50_out, 1'b0);
        chk(detect_done_out, 1'b0);
        chk(valid_cnt_out, 2'h0);
        power_down_input_in = 1'b0;
        step(5990, 6010, 2'h0, 1'b0);
        step(RDS_POLL_CYCLES, RDS_POLL_CYCLES, 2'h0, 1'b1);
        summarize();
    end
endmodule
